// ===== dv/proc_model.sv
// Processor-side model: crank angle sweep and per-cylinder injection points
`timescale 1ns/100ps
module proc_model (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  // Sweep enable
  input  wire logic                          i_run,
  // Angle and points
  output logic [16:0]                        o_angle,
  output inj_timing_pkg::injection_point_type o_points [20]
);
  // Angle in 1/128 degree steps, one engine cycle of 600 steps
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_angle <= 17'h00000;
    else if (i_run) o_angle <= (o_angle == 17'h00257) ? 17'h00000 : o_angle + 17'h00001;
  end
  // Partner cylinder half a cycle later, pulses far shorter than that
  always_comb begin
    for (int c = 0; c < 20; c++) begin
      o_points[c].start_angle = 17'((c % 2) * 300 + 10 + 20 * (c / 2));
      // Recomputed end moves earlier once the start has passed; the latched end must win
      o_points[c].end_angle = o_points[c].start_angle +
        ((o_angle > o_points[c].start_angle) ? 17'h00004 : 17'h00008);
    end
  end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the injection timing demultiplexer
`timescale 1ns/100ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic crank = 1'b0;
  logic phase = 1'b0;
  logic wdog = 1'b0;
  logic run = 1'b0;
  inj_timing_pkg::stroke_mode_type mode = inj_timing_pkg::mode_two_stroke;
  inj_timing_pkg::injection_point_type pts [20];
  logic [16:0] angle;
  logic        ref_pulse;
  logic [9:0]  line;
  logic [19:0] fire;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // Clock generation
  always #50 i_clk = ~i_clk;
  proc_model u_proc (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(run), .o_angle(angle),
    .o_points(pts));
  inj_timing_demux u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_crank_reference_pulse(crank),
    .i_phase_pulse(phase), .i_crank_angle(angle), .i_mode(mode), .i_points(pts),
    .i_watchdog_fault(wdog), .o_timing_reference(ref_pulse), .o_line_pulse(line),
    .o_fire_command(fire));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Pulse pins, then count forwarded references in a bounded window
  task automatic pins(logic c, logic p, logic [31:0] exp);
    logic [31:0] cnt;
    cnt = 0;
    crank = c;
    phase = p;
    step(2);
    crank = 1'b0;
    phase = 1'b0;
    for (int i = 0; i < 8; i++) begin
      step(1);
      if (ref_pulse === 1'b1) cnt++;
    end
    chk("timing_reference", cnt, exp);
  endtask
  // Sweep whole cycles, record edges of every fire command and line
  task automatic sweep(int n, logic wd);
    int nr[20], ra[20], fa[20], nl[10];
    logic [19:0] pf;
    logic [9:0] pl;
    nr = '{default: 0};
    nl = '{default: 0};
    pf = fire;
    pl = line;
    wdog = wd;
    run = 1'b1;
    for (int i = 0; i < 600 * n; i++) begin
      step(1);
      for (int c = 0; c < 20; c++) begin
        if (fire[c] && !pf[c]) begin
          nr[c]++;
          ra[c] = angle;
        end
        if (!fire[c] && pf[c]) fa[c] = angle;
        if (c < 10 && line[c] && !pl[c]) nl[c]++;
      end
      pf = fire;
      pl = line;
    end
    run = 1'b0;
    wdog = 1'b0;
    for (int c = 0; c < 20; c++) begin
      chk("fire_count", nr[c], wd ? 0 : n);
      if (c < 10) chk("line_count", nl[c], 2 * n);
      if (!wd) chk("fire_start", ra[c], (c % 2) * 300 + 11 + 20 * (c / 2));
      if (!wd) chk("fire_end", fa[c], (c % 2) * 300 + 19 + 20 * (c / 2));
    end
  endtask
  // Two-stroke: each crank edge is a reference, phase edges change nothing
  task automatic scn_two_stroke();
    pins(1'b1, 1'b0, 1);
    pins(1'b0, 1'b1, 0);
  endtask
  // Four-stroke: only the first crank edge after a phase edge passes
  task automatic scn_four_stroke();
    mode = inj_timing_pkg::mode_four_stroke;
    pins(1'b1, 1'b0, 0);
    pins(1'b0, 1'b1, 0);
    pins(1'b1, 1'b0, 1);
    pins(1'b1, 1'b0, 0);
    pins(1'b0, 1'b1, 0);
    pins(1'b1, 1'b0, 1);
  endtask
  // Two whole cycles of fire commands in firing order
  task automatic scn_fire_order();
    sweep(2, 1'b0);
  endtask
  // Watchdog fault blanks one cycle, then firing resumes
  task automatic scn_watchdog();
    sweep(1, 1'b1);
    sweep(1, 1'b0);
  endtask
  // Main sequence
  initial begin
    step(3);
    i_rst_n = 1'b1;
    chk("reset_outputs", {ref_pulse, line, fire}, 0);
    scn_two_stroke();
    scn_four_stroke();
    scn_fire_order();
    scn_watchdog();
    end_sim();
  end
endmodule

// ===== hdl/inj_timing_demux.sv
// Crank reference selection, line scheduling and fire command demultiplexing
`timescale 1ns/100ps
module inj_timing_demux #(
  parameter int LINES = inj_timing_pkg::LINE_COUNT,
  parameter int AW    = inj_timing_pkg::ANGLE_WIDTH
) (
  // Clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_n,
  // Engine sensor pins
  input  wire logic                               i_crank_reference_pulse,
  input  wire logic                               i_phase_pulse,
  input  wire logic [AW-1:0]                      i_crank_angle,
  // Processor side
  input  wire inj_timing_pkg::stroke_mode_type    i_mode,
  input  wire inj_timing_pkg::injection_point_type i_points [2*LINES],
  input  wire logic                               i_watchdog_fault,
  // Outputs
  output logic                                    o_timing_reference,
  output logic [LINES-1:0]                        o_line_pulse,
  output logic [2*LINES-1:0]                      o_fire_command
);

  // Pin synchronisers
  logic [1:0] crank_sync;
  logic [1:0] phase_sync;
  logic       crank_last;
  logic       phase_armed;
  logic       next_phase_armed;
  logic       next_reference;
  logic       crank_rise;
  logic       phase_rise;
  logic       phase_last;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crank_sync <= 2'h0;
      phase_sync <= 2'h0;
    end else begin
      crank_sync <= {crank_sync[0], i_crank_reference_pulse};
      phase_sync <= {phase_sync[0], i_phase_pulse};
    end
  end

  // Rising edges of the synced pins; last values reset low like the idle pins,
  // so no false edge appears right after reset
  assign crank_rise = crank_sync[1] & ~crank_last;
  assign phase_rise = phase_sync[1] & ~phase_last;

  // Reference selection by mode
  always_comb begin
    next_phase_armed = phase_armed;
    next_reference   = 1'b0;
    if (i_mode == inj_timing_pkg::mode_two_stroke) begin
      next_reference   = crank_rise;
      next_phase_armed = 1'b0;
    end else begin
      if (crank_rise && phase_armed) begin
        next_reference   = 1'b1;
        next_phase_armed = 1'b0;
      end
      if (phase_rise) begin
        next_phase_armed = 1'b1;
      end
    end
  end

  // Edge history, phase arm flag and the one-cycle reference pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crank_last         <= 1'b0;
      phase_last         <= 1'b0;
      phase_armed        <= 1'b0;
      o_timing_reference <= 1'b0;
    end else begin
      crank_last         <= crank_sync[1];
      phase_last         <= phase_sync[1];
      phase_armed        <= next_phase_armed;
      o_timing_reference <= next_reference;
    end
  end

  // Per-line scheduler: one instance of logic per shared line
  logic [LINES-1:0]  second_half;
  logic [LINES-1:0]  next_second_half;
  logic [LINES-1:0]  pulse_on;
  logic [LINES-1:0]  next_pulse_on;
  logic [AW-1:0]     end_latch [LINES];
  logic [AW-1:0]     next_end_latch [LINES];
  logic [2*LINES-1:0] next_fire;

  // Next line state; equality compare, so the angle must step through every value
  always_comb begin
    for (int l = 0; l < LINES; l++) begin
      next_second_half[l] = second_half[l];
      next_pulse_on[l]    = pulse_on[l];
      next_end_latch[l]   = end_latch[l];
      if (!pulse_on[l]) begin
        // angles compared in 1/128 degree units
        if (i_crank_angle == i_points[2*l + int'(second_half[l])].start_angle) begin
          next_pulse_on[l]  = 1'b1;
          next_end_latch[l] = i_points[2*l + int'(second_half[l])].end_angle;
        end
      end else if (i_crank_angle == end_latch[l]) begin
        next_pulse_on[l]    = 1'b0;
        next_second_half[l] = ~second_half[l];
      end
      if (o_timing_reference && !pulse_on[l]) begin
        next_second_half[l] = 1'b0;
      end
    end
    // Demultiplex: cylinder 2l first pulse, 2l+1 second
    for (int c = 0; c < 2*LINES; c++) begin
      next_fire[c] = next_pulse_on[c/2] & (next_second_half[c/2] == c[0]);
    end
    // Fault blanks the fire commands only; the line view keeps showing the schedule
    if (i_watchdog_fault) begin
      next_fire = '0;
    end
  end

  // Register the scheduler state and the fire commands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      second_half    <= '0;
      pulse_on       <= '0;
      o_fire_command <= '0;
      for (int l = 0; l < LINES; l++) begin
        end_latch[l] <= inj_timing_pkg::ANGLE_RESET;
      end
    end else begin
      second_half    <= next_second_half;
      pulse_on       <= next_pulse_on;
      o_fire_command <= next_fire;
      for (int l = 0; l < LINES; l++) begin
        end_latch[l] <= next_end_latch[l];
      end
    end
  end

  // Shared processor-line view
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_pulse <= '0;
    end else begin
      o_line_pulse <= next_pulse_on;
    end
  end

  // Checks on fault blanking and reference selection
  a_watchdog_blank: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_watchdog_fault |=> o_fire_command == '0)
    else $error("fire while fault");
  a_two_stroke_ref: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mode == inj_timing_pkg::mode_two_stroke && crank_rise) |=> o_timing_reference)
    else $error("two-stroke reference lost");
  a_two_no_arm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mode == inj_timing_pkg::mode_two_stroke) |=> !phase_armed)
    else $error("phase armed in two-stroke");
  a_four_no_phase: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mode == inj_timing_pkg::mode_four_stroke && !phase_armed) |=> !o_timing_reference)
    else $error("reference without phase");
  a_ref_pulse_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_timing_reference |=> !o_timing_reference)
    else $error("reference too long");
  a_ref_from_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_timing_reference |-> $past(crank_rise))
    else $error("reference without crank edge");

  // Checks on line scheduling, line 0 in detail
  a_start_fires: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!pulse_on[0] && i_crank_angle == i_points[int'(second_half[0])].start_angle)
    |=> pulse_on[0])
    else $error("start point missed");
  a_end_latched: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(pulse_on[0]) |-> end_latch[0] == $past(i_points[int'(second_half[0])].end_angle))
    else $error("end angle not latched");
  a_end_stops: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pulse_on[0] && i_crank_angle == end_latch[0]) |=> !pulse_on[0])
    else $error("pulse outlived end point");
  a_end_toggles: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($fell(pulse_on[0]) && !$past(o_timing_reference))
    |-> second_half[0] != $past(second_half[0]))
    else $error("complement not armed");
  a_ref_resets_half: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_timing_reference && !pulse_on[0]) |=> !second_half[0])
    else $error("selector not rewound");
  a_first_to_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fire_command[0] |-> (pulse_on[0] && !second_half[0]))
    else $error("first pulse on wrong output");
  a_second_to_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fire_command[1] |-> (pulse_on[0] && second_half[0]))
    else $error("second pulse on wrong output");

  // Checks on demultiplexing
  a_pair_exclusive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_fire_command[0] & o_fire_command[1]) == 1'b0)
    else $error("pair overlap");
  a_line_matches: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_watchdog_fault |=> o_line_pulse[0] == (o_fire_command[0] | o_fire_command[1]))
    else $error("line and fire disagree");
  // Same pairing checks on every shared line
  for (genvar g = 0; g < LINES; g++) begin : g_line_chk
    a_pair_each: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_fire_command[2*g] & o_fire_command[2*g+1]) == 1'b0)
      else $error("pair overlap on a line");
    a_line_each: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_watchdog_fault |=> o_line_pulse[g] == (o_fire_command[2*g] | o_fire_command[2*g+1]))
      else $error("line and fire disagree on a line");
    a_high_each: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_fire_command[2*g+1] |-> second_half[g])
      else $error("partner pulse on wrong output");
  end

  // Main scenarios reached
  c_four_ref: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_mode == inj_timing_pkg::mode_four_stroke && o_timing_reference);
  c_two_ref: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_mode == inj_timing_pkg::mode_two_stroke && o_timing_reference);
  c_first_cyl: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_fire_command[0]);
  c_second_cyl: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_fire_command[1]);
  c_fire_blanked: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_watchdog_fault && o_line_pulse[0]);

endmodule

// ===== hdl/inj_timing_pkg.sv
// Package of constants and carrier types for the injection timing demultiplexer
package inj_timing_pkg;
  localparam int LINE_COUNT     = 10;
  localparam int CYL_COUNT      = 2 * LINE_COUNT;
  localparam int ANGLE_FRAC     = 7;          // 128 steps per degree
  localparam int ANGLE_WIDTH    = 17;         // 720 deg * 128 fits
  localparam logic [ANGLE_WIDTH-1:0] ANGLE_RESET = 17'h00000;

  typedef enum logic {
    mode_two_stroke,
    mode_four_stroke
  } stroke_mode_type;

  // Angle points for one cylinder
  typedef struct packed {
    logic [ANGLE_WIDTH-1:0] start_angle;
    logic [ANGLE_WIDTH-1:0] end_angle;
  } injection_point_type;
endpackage
